// File: design/datapath_pkg.sv
package datapath_pkg;
    // decoded operation codes; encoding chosen locally
    typedef enum logic [3:0] {
        OP_RL_CARRY  = 4'h0,
        OP_RR        = 4'h1,
        OP_RR_CARRY  = 4'h2,
        OP_SUB_BOR   = 4'h3,
        OP_SUB_MEM   = 4'h4,
        OP_SUB_IMM   = 4'h5,
        OP_DEC_SKIP  = 4'h6,
        OP_INC_SKIP  = 4'h7,
        OP_SET_BYTE  = 4'h8,
        OP_SET_BIT   = 4'h9,
        OP_BIT_SKIP  = 4'ha,
        OP_SWAP      = 4'hb
    } op_type;
endpackage

// File: design/datapath_regs.svh
`ifndef DATAPATH_REGS_SVH
`define DATAPATH_REGS_SVH
// register word offsets (byte addresses)
`define ACC_OFS        8'h00
`define FLAGS_OFS      8'h04
`define STATUS_OFS     8'h08
// flag field positions
`define FLAG_C_BIT     0
`define FLAG_AC_BIT    1
`define FLAG_Z_BIT     2
`define FLAG_OV_BIT    3
// status field positions
`define STAT_DUMMY_BIT 0
`define STAT_OP_LSB    4
// reset values
`define ACC_RST        8'h00
`define FLAGS_RST      4'h0
// cycles per instruction without and with a skip
`define EXEC_CYCLES    1
`define SKIP_CYCLES    2
`endif

// File: design/mcu_rotate_subtract_skip_datapath.sv
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "datapath_regs.svh"

// Contract
// - rotate left through carry to memory: carry into bit 0, bit 7 to carry.
// - rotate left through carry to accumulator; carry from bit 7; memory untouched.
// - rotate right to memory, bit 0 wraps into bit 7, flags unchanged.
// - rotate right to accumulator, memory unchanged, flags unchanged.
// - rotate right through carry to memory; only carry changes.
// - rotate right through carry to accumulator; carry from bit 0; memory untouched.
// - subtract with borrow: acc plus inverted byte plus carry into acc, four flags.
// - same subtract with borrow, result written to memory instead.
// - decrement memory byte, write back, skip when zero, flags unchanged.
// - decrement into accumulator, memory untouched, skip when zero.
// - a taken skip drops the prefetched instruction: two cycles, else one.
// - whole-byte set writes all ones to memory, flags unchanged.
// - single-bit set forces selected bit to one, keeps seven others, no flags.
// - increment memory byte, write back, skip when it wraps to zero.
// - increment into accumulator, memory unchanged, skip when zero.
// - bit test skips when selected bit is one; no data or flag change.
// - subtract memory: acc plus inverted byte plus one, to acc or memory.
// - subtract immediate: acc plus inverted immediate plus one into acc.
// - nibble swap to memory or to accumulator, no flags affected.
module mcu_rotate_subtract_skip_datapath
    import datapath_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        exec_valid,
    input  wire op_type      exec_op,
    input  wire logic        exec_to_acc,
    input  wire logic [2:0]  exec_bit,
    input  wire logic [7:0]  exec_imm,
    input  wire logic [7:0]  mem_rdata,
    output logic             exec_ready,
    output logic             discard_fetch,
    output logic             mem_we,
    output logic      [7:0]  mem_wdata,
    output logic      [7:0]  acc_value,
    output logic             carry_flag,
    output logic             nibble_carry_flag,
    output logic             zero_flag,
    output logic             signed_wrap_flag
);

    logic [7:0]  acc_reg,       acc_next;
    logic [3:0]  flags_reg,     flags_next;
    logic        mem_we_reg,    mem_we_next;
    logic [7:0]  mem_wdata_reg, mem_wdata_next;
    logic        dummy_reg,     dummy_next;
    logic [3:0]  last_op_reg,   last_op_next;
    logic        ack_reg,       ack_next;
    logic [31:0] rdata_reg,     rdata_next;
    logic        exec_go;
    logic        bus_wr;
    logic [7:0]  sub_b;
    logic        sub_cin;
    logic [8:0]  sub_sum;
    logic [4:0]  sub_lo;
    logic        sub_ov;
    logic [7:0]  res;
    logic        wr_res;
    logic        skip;

    // the decoder may not issue while the dummy cycle runs
    assign exec_go = exec_valid && !dummy_reg;
    // only lane 0 carries register bits, so a write without it must not land
    assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];

    // shared subtractor: a + ~b + cin covers all three subtract forms
    assign sub_b   = (exec_op == OP_SUB_IMM) ? exec_imm : mem_rdata;
    assign sub_cin = (exec_op == OP_SUB_BOR) ? flags_reg[`FLAG_C_BIT] : 1'b1;
    assign sub_sum = {1'b0, acc_reg} + {1'b0, ~sub_b} + {8'h00, sub_cin};
    assign sub_lo  = {1'b0, acc_reg[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
    assign sub_ov  = (acc_reg[7] == ~sub_b[7]) && (sub_sum[7] != acc_reg[7]);

    // operation decode and result steering
    always_comb begin
        acc_next       = acc_reg;
        flags_next     = flags_reg;
        mem_we_next    = 1'b0;
        mem_wdata_next = mem_wdata_reg;
        dummy_next     = 1'b0;
        last_op_next   = last_op_reg;
        res            = 8'h00;
        wr_res         = 1'b0;
        skip           = 1'b0;
        // software writes first so that a same-cycle instruction wins
        if (bus_wr && wb_adr_i == `ACC_OFS) begin
            acc_next = wb_dat_i[7:0];
        end
        if (bus_wr && wb_adr_i == `FLAGS_OFS) begin
            flags_next = wb_dat_i[3:0];
        end
        if (exec_go) begin
            last_op_next = exec_op;
            unique case (exec_op)
                OP_RL_CARRY: begin
                    res    = {mem_rdata[6:0], flags_reg[`FLAG_C_BIT]};
                    wr_res = 1'b1;
                    flags_next[`FLAG_C_BIT] = mem_rdata[7];
                end
                OP_RR: begin
                    res    = {mem_rdata[0], mem_rdata[7:1]};
                    wr_res = 1'b1;
                end
                OP_RR_CARRY: begin
                    res    = {flags_reg[`FLAG_C_BIT], mem_rdata[7:1]};
                    wr_res = 1'b1;
                    flags_next[`FLAG_C_BIT] = mem_rdata[0];
                end
                OP_SUB_BOR, OP_SUB_MEM, OP_SUB_IMM: begin
                    res    = sub_sum[7:0];
                    wr_res = 1'b1;
                    flags_next[`FLAG_C_BIT]  = sub_sum[8];
                    flags_next[`FLAG_AC_BIT] = sub_lo[4];
                    flags_next[`FLAG_Z_BIT]  = (sub_sum[7:0] == 8'h00);
                    flags_next[`FLAG_OV_BIT] = sub_ov;
                end
                OP_DEC_SKIP: begin
                    res    = mem_rdata - 8'h01;
                    wr_res = 1'b1;
                    skip   = (res == 8'h00);
                end
                OP_INC_SKIP: begin
                    res    = mem_rdata + 8'h01;
                    wr_res = 1'b1;
                    skip   = (res == 8'h00);
                end
                OP_SET_BYTE: begin
                    res    = 8'hff;
                    wr_res = 1'b1;
                end
                OP_SET_BIT: begin
                    res    = mem_rdata | (8'h01 << exec_bit);
                    wr_res = 1'b1;
                end
                OP_BIT_SKIP: begin
                    // look only: the byte is neither written nor flagged
                    skip = mem_rdata[exec_bit];
                end
                OP_SWAP: begin
                    res    = {mem_rdata[3:0], mem_rdata[7:4]};
                    wr_res = 1'b1;
                end
                default: begin
                    // undefined code acts as a no-op
                    wr_res = 1'b0;
                end
            endcase
            // set and immediate forms have a fixed destination
            if (wr_res) begin
                if ((exec_to_acc || exec_op == OP_SUB_IMM) &&
                    exec_op != OP_SET_BYTE && exec_op != OP_SET_BIT) begin
                    acc_next = res;
                end else begin
                    mem_we_next    = 1'b1;
                    mem_wdata_next = res;
                end
            end
            dummy_next = skip;
        end
    end

    // datapath state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg       <= `ACC_RST;
            flags_reg     <= `FLAGS_RST;
            mem_we_reg    <= 1'b0;
            mem_wdata_reg <= 8'h00;
            dummy_reg     <= 1'b0;
            last_op_reg   <= 4'h0;
        end else begin
            acc_reg       <= acc_next;
            flags_reg     <= flags_next;
            mem_we_reg    <= mem_we_next;
            mem_wdata_reg <= mem_wdata_next;
            dummy_reg     <= dummy_next;
            last_op_reg   <= last_op_next;
        end
    end

    // wishbone slave: one wait state, unmapped reads give zero
    // status is read-only: a write there is acked and dropped
    always_comb begin
        ack_next   = wb_cyc_i && wb_stb_i && !ack_reg;
        rdata_next = 32'h0000_0000;
        if (ack_next && !wb_we_i) begin
            unique case (wb_adr_i)
                `ACC_OFS:    rdata_next[7:0] = acc_reg;
                `FLAGS_OFS:  rdata_next[3:0] = flags_reg;
                `STATUS_OFS: begin
                    rdata_next[`STAT_DUMMY_BIT]              = dummy_reg;
                    rdata_next[`STAT_OP_LSB+3:`STAT_OP_LSB] = last_op_reg;
                end
                default:     rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // output drive
    assign wb_ack_o          = ack_reg;
    assign wb_dat_o          = rdata_reg;
    assign exec_ready        = !dummy_reg;
    assign discard_fetch     = dummy_reg;
    assign mem_we            = mem_we_reg;
    assign mem_wdata         = mem_wdata_reg;
    assign acc_value         = acc_reg;
    assign carry_flag        = flags_reg[`FLAG_C_BIT];
    assign nibble_carry_flag = flags_reg[`FLAG_AC_BIT];
    assign zero_flag         = flags_reg[`FLAG_Z_BIT];
    assign signed_wrap_flag  = flags_reg[`FLAG_OV_BIT];

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    logic go_mem;
    logic go_acc;
    assign go_mem = exec_go && !exec_to_acc;
    assign go_acc = exec_go && exec_to_acc;

    // per-operation results, checked one cycle after issue
    rlc_mem_a: assert property (go_mem && exec_op == OP_RL_CARRY |=>
        mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(carry_flag)}
        && carry_flag == $past(mem_rdata[7]))
        else $error("rotate left through carry to memory wrong");
    rlc_acc_a: assert property (go_acc && exec_op == OP_RL_CARRY |=>
        !mem_we && acc_value == {$past(mem_rdata[6:0]), $past(carry_flag)}
        && carry_flag == $past(mem_rdata[7]))
        else $error("rotate left through carry to acc wrong");
    rr_mem_a: assert property (go_mem && exec_op == OP_RR && !bus_wr |=>
        mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
        && $stable(flags_reg))
        else $error("rotate right to memory wrong");
    rr_acc_a: assert property (go_acc && exec_op == OP_RR && !bus_wr |=>
        !mem_we && $stable(flags_reg)
        && acc_value == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("rotate right to acc wrong");
    rrc_mem_a: assert property (go_mem && exec_op == OP_RR_CARRY && !bus_wr |=>
        mem_wdata[7] == $past(carry_flag) && carry_flag == $past(mem_rdata[0])
        && $stable(flags_reg[3:1]))
        else $error("rotate right through carry wrong");
    rrc_acc_a: assert property (go_acc && exec_op == OP_RR_CARRY |=>
        !mem_we && acc_value == {$past(carry_flag), $past(mem_rdata[7:1])})
        else $error("rotate right through carry to acc wrong");
    sbc_acc_a: assert property (go_acc && exec_op == OP_SUB_BOR |=>
        {~carry_flag, acc_value} == {1'b0, $past(acc_reg)} - {1'b0, $past(mem_rdata)}
        - {8'h00, ~$past(carry_flag)} && zero_flag == (acc_value == 8'h00))
        else $error("subtract with borrow wrong");
    sbc_mem_a: assert property (go_mem && exec_op == OP_SUB_BOR |=>
        mem_we && mem_wdata == $past(acc_reg) - $past(mem_rdata) - {7'h00, ~$past(carry_flag)})
        else $error("subtract with borrow to memory wrong");
    dec_skip_a: assert property (exec_go && exec_op == OP_DEC_SKIP
        && mem_rdata == 8'h01 |=> discard_fetch && !exec_ready)
        else $error("decrement skip missing");
    skip_len_a: assert property (discard_fetch |=> !discard_fetch && exec_ready)
        else $error("dummy cycle longer than one");
    set_byte_a: assert property (exec_go && exec_op == OP_SET_BYTE && !bus_wr |=>
        mem_we && mem_wdata == 8'hff && $stable(flags_reg))
        else $error("byte set wrong");
    set_bit_a: assert property (exec_go && exec_op == OP_SET_BIT |=>
        mem_wdata[$past(exec_bit)] && (mem_wdata | (8'h01 << $past(exec_bit)))
        == ($past(mem_rdata) | (8'h01 << $past(exec_bit))))
        else $error("bit set wrong");
    inc_skip_a: assert property (exec_go && exec_op == OP_INC_SKIP
        && mem_rdata != 8'hff |=> !discard_fetch)
        else $error("increment skipped without wrap");
    bit_test_a: assert property (exec_go && exec_op == OP_BIT_SKIP |=>
        !mem_we && discard_fetch == $past(mem_rdata[exec_bit]))
        else $error("bit test skip wrong");
    sub_imm_a: assert property (exec_go && exec_op == OP_SUB_IMM |=>
        !mem_we && acc_value == $past(acc_reg) - $past(exec_imm))
        else $error("subtract immediate wrong");
    swap_a: assert property (go_mem && exec_op == OP_SWAP |=>
        mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("nibble swap wrong");

    // skip timing and the refused prefetch
    one_cycle_a: assert property (exec_go && !skip |=> exec_ready && !discard_fetch)
        else $error("dummy cycle without a skip");
    refuse_a: assert property (discard_fetch && !bus_wr |=>
        !mem_we && $stable(acc_reg))
        else $error("discarded instruction executed");

    // counting, subtract and set results on the other destination
    dec_mem_a: assert property (go_mem && exec_op == OP_DEC_SKIP && !bus_wr |=>
        mem_we && mem_wdata == $past(mem_rdata) - 8'h01 && $stable(flags_reg))
        else $error("decrement to memory wrong");
    dec_acc_a: assert property (go_acc && exec_op == OP_DEC_SKIP |=>
        !mem_we && acc_value == $past(mem_rdata) - 8'h01
        && discard_fetch == (acc_value == 8'h00))
        else $error("decrement to acc wrong");
    inc_acc_a: assert property (go_acc && exec_op == OP_INC_SKIP && !bus_wr |=>
        !mem_we && acc_value == $past(mem_rdata) + 8'h01 && $stable(flags_reg)
        && discard_fetch == (acc_value == 8'h00))
        else $error("increment to acc wrong");
    sub_mem_a: assert property (go_mem && exec_op == OP_SUB_MEM |=>
        mem_we && mem_wdata == $past(acc_reg) - $past(mem_rdata)
        && carry_flag == ($past(acc_reg) >= $past(mem_rdata)))
        else $error("subtract to memory wrong");
    sub_flags_a: assert property (exec_go && exec_op == OP_SUB_IMM |=>
        carry_flag == ($past(acc_reg) >= $past(exec_imm))
        && zero_flag == (acc_value == 8'h00)
        && nibble_carry_flag == ($past(acc_reg[3:0]) >= $past(exec_imm[3:0])))
        else $error("subtract immediate flags wrong");
    sbc_ov_a: assert property (go_acc && exec_op == OP_SUB_BOR |=>
        signed_wrap_flag == (($past(acc_reg[7]) != $past(mem_rdata[7]))
        && (acc_value[7] != $past(acc_reg[7]))))
        else $error("subtract with borrow overflow wrong");
    set_fixed_a: assert property (go_acc && !bus_wr
        && (exec_op == OP_SET_BYTE || exec_op == OP_SET_BIT) |=> mem_we && $stable(acc_reg))
        else $error("set wrote the accumulator");

    // bus side: ack is a single pulse and never comes unasked
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    ack_asked_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");

    // scenarios worth seeing at least once
    skip_taken_c: cover property (exec_go && skip ##1 discard_fetch ##1 exec_go);
    sub_borrow_c: cover property (exec_go && exec_op == OP_SUB_BOR && !carry_flag);
    bus_read_c:   cover property (wb_cyc_i && wb_stb_i && !wb_we_i ##1 wb_ack_o);
    inc_wrap_c:   cover property (exec_go && exec_op == OP_INC_SKIP && mem_rdata == 8'hff);
    bit_skip_c:   cover property (exec_go && exec_op == OP_BIT_SKIP ##1 discard_fetch);

endmodule
`default_nettype wire

// File: testbench/data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
    input  wire logic       clk_sys,
    input  wire logic [6:0] mem_addr,
    input  wire logic       mem_we,
    input  wire logic [7:0] mem_wdata,
    output logic      [7:0] mem_rdata
);
    logic [7:0] mem [128];
    // preload repeats four values so that wrap and skip cases come up
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = (i % 4 == 0) ? 8'h01 : (i % 4 == 1) ? 8'hff : (i % 4 == 2) ? 8'h80 : 8'h0f;
        end
    end
    // byte read is combinational, valid while the address is held
    assign mem_rdata = mem[mem_addr];
    // write lands at the edge that closes the one-cycle pulse
    always @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import datapath_pkg::*;
;
    logic clk_sys = 1'b0, reset_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic exec_valid = 1'b0, exec_to_acc = 1'b0, exec_ready, discard_fetch, mem_we;
    op_type exec_op = OP_RL_CARRY;
    logic [2:0] exec_bit = 3'h0;
    logic [7:0] exec_imm = 8'h00, mem_rdata, mem_wdata, acc_value, e_acc;
    logic [6:0] mem_addr = 7'h00;
    logic carry_flag, nibble_carry_flag, zero_flag, signed_wrap_flag, e_c, e_ac, e_z, e_ov;
    logic [7:0] exp_mem [128];
    int fails = 0, n_compared = 0;
    mcu_rotate_subtract_skip_datapath i_mcu_rotate_subtract_skip_datapath (
        .clk_sys           (clk_sys),
        .reset_n           (reset_n),
        .wb_cyc_i          (wb_cyc_i),
        .wb_stb_i          (wb_stb_i),
        .wb_we_i           (wb_we_i),
        .wb_adr_i          (wb_adr_i),
        .wb_sel_i          (wb_sel_i),
        .wb_dat_i          (wb_dat_i),
        .wb_dat_o          (wb_dat_o),
        .wb_ack_o          (wb_ack_o),
        .exec_valid        (exec_valid),
        .exec_op           (exec_op),
        .exec_to_acc       (exec_to_acc),
        .exec_bit          (exec_bit),
        .exec_imm          (exec_imm),
        .mem_rdata         (mem_rdata),
        .exec_ready        (exec_ready),
        .discard_fetch     (discard_fetch),
        .mem_we            (mem_we),
        .mem_wdata         (mem_wdata),
        .acc_value         (acc_value),
        .carry_flag        (carry_flag),
        .nibble_carry_flag (nibble_carry_flag),
        .zero_flag         (zero_flag),
        .signed_wrap_flag  (signed_wrap_flag)
    );
    data_mem_model i_data_mem_model (
        .clk_sys   (clk_sys),
        .mem_addr  (mem_addr),
        .mem_we    (mem_we),
        .mem_wdata (mem_wdata),
        .mem_rdata (mem_rdata)
    );
    always #2.5 clk_sys = ~clk_sys;
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one classic cycle; waits for ack, then idles a cycle
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] sel);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
        wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= sel;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        @(posedge clk_sys);
        if (n >= 20) chk("ack", 32'h1, 32'h0);
    endtask
    // issue one instruction with a reference result; entered and left at an edge
    task automatic run_op(input op_type op, input logic ta, input logic [6:0] a);
        logic [7:0] m, r, x;
        logic [8:0] s;
        logic [4:0] h;
        logic [2:0] b;
        logic cin, we, wa, sk;
        m = exp_mem[a]; b = {a[1:0], ta};
        x = (op == OP_SUB_IMM) ? ~(m ^ 8'h5a) : ~m;
        cin = (op == OP_SUB_BOR) ? e_c : 1'b1;
        s = {1'b0, e_acc} + {1'b0, x} + {8'h00, cin};
        h = {1'b0, e_acc[3:0]} + {1'b0, x[3:0]} + {4'h0, cin};
        sk = 1'b0; wa = ta; we = !ta; r = m;
        case (op)
            OP_RL_CARRY: begin r = {m[6:0], e_c}; e_c = m[7]; end
            OP_RR: r = {m[0], m[7:1]};
            OP_RR_CARRY: begin r = {e_c, m[7:1]}; e_c = m[0]; end
            OP_SUB_BOR, OP_SUB_MEM, OP_SUB_IMM: begin
                r = s[7:0]; e_c = s[8]; e_ac = h[4]; e_z = (r == 8'h00);
                e_ov = (e_acc[7] == x[7]) && (r[7] != e_acc[7]);
            end
            OP_DEC_SKIP: begin r = m - 8'h01; sk = (r == 8'h00); end
            OP_INC_SKIP: begin r = m + 8'h01; sk = (r == 8'h00); end
            OP_SET_BYTE: begin r = 8'hff; wa = 1'b0; we = 1'b1; end
            OP_SET_BIT: begin r = m | (8'h01 << b); wa = 1'b0; we = 1'b1; end
            OP_BIT_SKIP: begin sk = m[b]; wa = 1'b0; we = 1'b0; end
            default: r = {m[3:0], m[7:4]};
        endcase
        if (op == OP_SUB_IMM) begin wa = 1'b1; we = 1'b0; end
        if (wa) e_acc = r;
        if (we) exp_mem[a] = r;
        exec_valid <= 1'b1; exec_op <= op; exec_to_acc <= ta;
        exec_bit <= b; exec_imm <= m ^ 8'h5a; mem_addr <= a;
        @(posedge clk_sys);
        // the prefetched instruction stays offered during a dummy cycle
        exec_valid <= sk; exec_op <= OP_SET_BYTE; exec_to_acc <= 1'b0;
        #1;
        chk("acc", {24'h0, e_acc}, {24'h0, acc_value});
        chk("flags", {28'h0, e_ov, e_z, e_ac, e_c}, {28'h0, signed_wrap_flag, zero_flag,
            nibble_carry_flag, carry_flag});
        chk("mem_we", {31'h0, we}, {31'h0, mem_we});
        if (we) chk("mem_wdata", {24'h0, r}, {24'h0, mem_wdata});
        chk("skip", {30'h0, sk, !sk}, {30'h0, discard_fetch, exec_ready});
        if (sk) begin
            @(posedge clk_sys);
            exec_valid <= 1'b0;
            #1;
            chk("dummy", 32'h1, {29'h0, mem_we, discard_fetch, exec_ready});
        end
        @(posedge clk_sys);
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < 128; i++) begin
            exp_mem[i] = (i % 4 == 0) ? 8'h01 : (i % 4 == 1) ? 8'hff : (i % 4 == 2) ? 8'h80 : 8'h0f;
        end
        repeat (20) @(posedge clk_sys);
        chk("reset outputs", 32'h1, {29'h0, mem_we, discard_fetch, exec_ready});
        reset_n <= 1'b1;
        wb_xfer(1'b0, 8'h00, 32'h0, 4'hf);
        chk("acc reset", 32'h0, rd);
        wb_xfer(1'b0, 8'h04, 32'h0, 4'hf);
        chk("flags reset", 32'h0, rd);
        wb_xfer(1'b1, 8'h00, 32'h3c, 4'h1);
        wb_xfer(1'b1, 8'h00, 32'h55, 4'h0);
        wb_xfer(1'b1, 8'h40, 32'h77, 4'hf);
        wb_xfer(1'b0, 8'h40, 32'h0, 4'hf);
        chk("unmapped", 32'h0, rd);
        wb_xfer(1'b0, 8'h00, 32'h0, 4'hf);
        chk("acc", 32'h3c, rd);
        wb_xfer(1'b1, 8'h04, 32'h1, 4'h1);
        e_acc = 8'h3c; e_c = 1'b1; e_ac = 1'b0; e_z = 1'b0; e_ov = 1'b0;
        // every operation, both destinations, four memory values
        for (int o = 0; o < 12; o++) begin
            for (int t = 0; t < 2; t++) begin
                for (int k = 0; k < 4; k++) begin
                    run_op(op_type'(o[3:0]), t[0], {o[3:0], t[0], k[1:0]});
                end
            end
        end
        wb_xfer(1'b0, 8'h04, 32'h0, 4'hf);
        chk("flags", {28'h0, e_ov, e_z, e_ac, e_c}, rd);
        wb_xfer(1'b0, 8'h08, 32'h0, 4'hf);
        chk("status", 32'hb0, rd);
        for (int i = 0; i < 128; i++) begin
            chk("memory", {24'h0, exp_mem[i]}, {24'h0, i_data_mem_model.mem[i]});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
